// >>> rtl/dac_host_serial_interface.sv
// Host interface front end: parallel queue, serial port, readback and reset sequencing.
// Functional notes
// - Sample FIFO enable pin after power-up, clear and reset sequences.
// - Queue works only in parallel mode, holding up to 128 writes.
// - Writes arriving while the queue is full are ignored.
// - Busy stays low while queued writes execute; new writes still accepted.
// - Power-on reset loads defaults, floats outputs, holds busy low.
// - Power-down keeps every stored register value.
// - Select pins choose parallel or clocked serial port; bus select high turns the serial port off.
// - Interface wakes fully only on write strobe or frame sync fall.
// - Frame is 24 bits MSB first: bank, read, address, select, data, pad.
// - Bank bit picks A or B only while toggle mode is on.
// - Standalone: frame sync fall starts a frame and clears the bit count.
// - Standalone: stop shifting after 24 bits until next sync fall.
// - Chain mode shifts every clock while sync low; extra bits go out.
// - Chain output changes on serial clock rising edges.
// - Sync rise after full frame latches it and stops shifting.
// - Sync rise before 24 clocks discards the frame.
// - Read frame selects a register shown on the output next frame.
// - Readback word: top 10 address bits, 12 data bits; zero frame clocks it.
// - Readback first bit appears on the sync falling edge.
// - During reset busy, interfaces and load pulses are ignored.
// - Reset pin fall starts 270 us busy sequence; pin ignored meanwhile.
`timescale 1ns/10ps
`default_nettype none
module dac_host_serial_interface #(
    parameter int QUEUE_DEPTH = 128,
    parameter int EXEC_CYCLES = 4
) (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Device pins.
    input  wire dac_host_serial_pkg::pin_type pins,
    // Outputs.
    output var  logic        busy_n,
    output var  logic        serial_data_out,
    output var  logic        dac_update_pulse,
    output var  logic        outputs_hiz,
    output var  logic        interface_awake,
    output var  logic        power_down,
    output var  logic        reg_write_valid,
    output var  dac_host_serial_pkg::instr_type reg_write_instr
);
    localparam int QW = $clog2(QUEUE_DEPTH);

    dac_host_serial_pkg::pin_type   s1_reg, s2_reg, s3_reg;
    dac_host_serial_pkg::seq_type   seq_reg;
    dac_host_serial_pkg::instr_type queue_mem [QUEUE_DEPTH];
    dac_host_serial_pkg::instr_type head;
    dac_host_serial_pkg::frame_type frame_in;
    logic [11:0]   store_mem [512];
    logic [11:0]   seq_cnt_reg;
    logic [11:0]   clear_code_reg;
    logic [QW-1:0] wptr_reg, rptr_reg;
    logic [QW:0]   count_reg, cap;
    logic [7:0]    exec_cnt_reg;
    logic [4:0]    bit_cnt_reg;
    logic [23:0]   shift_reg, out_sr_reg, rb_word_reg, last_frame_reg;
    logic [15:0]   bad_frames_reg;
    logic          fifo_active_reg, toggle_reg, ready_reg, load_pending_reg;
    logic          frame_active_reg, first_fall_reg, rb_pending_reg, rb_active_reg;
    logic          seq_block, ser_en, par_mode, push, pop, exec_done, busy_now;
    logic          sync_fall, sync_rise, sclk_fall, sclk_rise, wr_rise, wr_fall;
    logic          reset_fall, clear_fall, load_fall, frame_end, frame_good, par_write;
    logic [8:0]    rb_idx;

    // Two-flop synchronisers on every pin, plus one stage for edge detection.
    always_ff @(posedge clk_sys) begin
        s1_reg <= pins;
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
    end

    assign sync_fall  = !s2_reg.sync_n && s3_reg.sync_n;
    assign sync_rise  = s2_reg.sync_n && !s3_reg.sync_n;
    assign sclk_fall  = !s2_reg.sclk && s3_reg.sclk;
    assign sclk_rise  = s2_reg.sclk && !s3_reg.sclk;
    assign wr_rise    = s2_reg.wr_n && !s3_reg.wr_n;
    assign wr_fall    = !s2_reg.wr_n && s3_reg.wr_n;
    assign reset_fall = !s2_reg.reset_n && s3_reg.reset_n;
    assign clear_fall = !s2_reg.clear_n && s3_reg.clear_n;
    assign load_fall  = !s2_reg.load_n && s3_reg.load_n;

    assign seq_block = (seq_reg == dac_host_serial_pkg::SEQ_POR)
                    || (seq_reg == dac_host_serial_pkg::SEQ_RESET);
    assign par_mode  = !s2_reg.serial_parallel_select;
    assign ser_en    = s2_reg.serial_parallel_select && !s2_reg.bus_select
                    && !seq_block;

    // Reset, power-on and clear sequencing with a walker that loads the store.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            seq_reg         <= dac_host_serial_pkg::SEQ_POR;
            seq_cnt_reg     <= 12'h000;
            fifo_active_reg <= 1'b0;
        end else begin
            case (seq_reg)
                dac_host_serial_pkg::SEQ_IDLE: begin
                    seq_cnt_reg <= 12'h000;
                    if (reset_fall) begin
                        seq_reg <= dac_host_serial_pkg::SEQ_RESET;
                    end else if (clear_fall) begin
                        seq_reg <= dac_host_serial_pkg::SEQ_CLEAR;
                    end
                end
                dac_host_serial_pkg::SEQ_POR, dac_host_serial_pkg::SEQ_RESET,
                dac_host_serial_pkg::SEQ_CLEAR: begin
                    seq_cnt_reg <= seq_cnt_reg + 12'h001;
                    if ((seq_reg == dac_host_serial_pkg::SEQ_POR
                            && seq_cnt_reg == dac_host_serial_pkg::POR_CYCLES - 12'h001)
                        || (seq_reg == dac_host_serial_pkg::SEQ_RESET
                            && seq_cnt_reg == dac_host_serial_pkg::RESET_CYCLES - 12'h001)
                        || (seq_reg == dac_host_serial_pkg::SEQ_CLEAR
                            && seq_cnt_reg == dac_host_serial_pkg::CLEAR_CYCLES - 12'h001)) begin
                        seq_reg         <= dac_host_serial_pkg::SEQ_IDLE;
                        fifo_active_reg <= s2_reg.fifo_enable;
                    end
                end
                default: seq_reg <= dac_host_serial_pkg::SEQ_IDLE;
            endcase
        end
    end

    // Instruction queue; capacity is one outside parallel FIFO mode.
    assign cap       = (fifo_active_reg && par_mode) ? (QW+1)'(QUEUE_DEPTH) : (QW+1)'(1);
    assign par_write = par_mode && wr_rise && !s2_reg.cs_n && !seq_block;
    assign push      = (par_write || (frame_good && !frame_in.read))
                    && (count_reg < cap);
    assign pop       = (count_reg != '0) && (exec_cnt_reg == 8'h00)
                    && (seq_reg == dac_host_serial_pkg::SEQ_IDLE);
    assign exec_done = (exec_cnt_reg == 8'h01);
    assign head      = queue_mem[rptr_reg];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            if (par_write) begin
                queue_mem[wptr_reg] <= {1'b0, s2_reg.channel_address,
                                        s2_reg.reg_sel, s2_reg.data_word};
            end else begin
                queue_mem[wptr_reg] <= {frame_in.bank & toggle_reg, frame_in.channel_address,
                                        frame_in.reg_sel, frame_in.data_word};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || seq_block) begin
            wptr_reg        <= '0;
            rptr_reg        <= '0;
            count_reg       <= '0;
            exec_cnt_reg    <= 8'h00;
            reg_write_valid <= 1'b0;
            reg_write_instr <= '0;
        end else begin
            reg_write_valid <= exec_done;
            if (push) begin
                wptr_reg <= wptr_reg + QW'(1);
            end
            if (pop) begin
                rptr_reg        <= rptr_reg + QW'(1);
                exec_cnt_reg    <= 8'(EXEC_CYCLES);
                reg_write_instr <= head;
            end else if (exec_cnt_reg != 8'h00) begin
                exec_cnt_reg <= exec_cnt_reg - 8'h01;
            end
            count_reg <= count_reg + (QW+1)'(push) - (QW+1)'(pop);
        end
    end

    // Register store; contents survive power-down untouched.
    always_ff @(posedge clk_sys) begin
        if (seq_block && seq_cnt_reg < 12'(dac_host_serial_pkg::STORE_SIZE)) begin
            store_mem[seq_cnt_reg[8:0]] <=
                (seq_cnt_reg[1:0] == dac_host_serial_pkg::REG_SEL_GAIN)
                ? dac_host_serial_pkg::GAIN_RESET : dac_host_serial_pkg::OTHER_RESET;
        end else if (seq_reg == dac_host_serial_pkg::SEQ_CLEAR
                     && seq_cnt_reg < 12'(dac_host_serial_pkg::STORE_SIZE)
                     && seq_cnt_reg[1:0] == dac_host_serial_pkg::REG_SEL_DATA) begin
            store_mem[seq_cnt_reg[8:0]] <= clear_code_reg;
        end else if (exec_done) begin
            store_mem[{reg_write_instr.bank, reg_write_instr.channel_address,
                       reg_write_instr.reg_sel}] <= reg_write_instr.data_word;
        end
    end

    // Serial frame capture.
    assign frame_in   = dac_host_serial_pkg::frame_type'(shift_reg);
    assign frame_end  = ser_en && sync_rise && frame_active_reg;
    assign frame_good = frame_end && (bit_cnt_reg == dac_host_serial_pkg::FRAME_BITS);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_active_reg <= 1'b0;
            first_fall_reg   <= 1'b0;
            bit_cnt_reg      <= 5'h00;
            shift_reg        <= 24'h000000;
        end else if (!ser_en) begin
            frame_active_reg <= 1'b0;
        end else if (sync_fall) begin
            frame_active_reg <= 1'b1;
            first_fall_reg   <= 1'b0;
            bit_cnt_reg      <= 5'h00;
        end else if (sync_rise) begin
            frame_active_reg <= 1'b0;
        end else if (frame_active_reg && !s2_reg.sync_n && sclk_fall
                     && (s2_reg.chain_enable_pin
                         || bit_cnt_reg < dac_host_serial_pkg::FRAME_BITS)) begin
            shift_reg      <= {shift_reg[22:0], s2_reg.din};
            first_fall_reg <= 1'b1;
            if (bit_cnt_reg != dac_host_serial_pkg::FRAME_BITS) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // Readback and chain output.
    assign rb_idx = {frame_in.bank & toggle_reg, frame_in.channel_address, frame_in.reg_sel};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rb_pending_reg  <= 1'b0;
            rb_active_reg   <= 1'b0;
            rb_word_reg     <= 24'h000000;
            out_sr_reg      <= 24'h000000;
            serial_data_out <= 1'b0;
        end else if (ser_en) begin
            if (frame_good && frame_in.read) begin
                rb_pending_reg <= 1'b1;
                rb_word_reg    <= {shift_reg[23:14], store_mem[rb_idx], 2'b00};
            end
            if (sync_fall) begin
                rb_active_reg <= rb_pending_reg;
                if (rb_pending_reg) begin
                    rb_pending_reg  <= 1'b0;
                    out_sr_reg      <= rb_word_reg;
                    serial_data_out <= rb_word_reg[23];
                end
            end else if (sclk_rise && frame_active_reg && first_fall_reg) begin
                if (rb_active_reg) begin
                    out_sr_reg      <= {out_sr_reg[22:0], 1'b0};
                    serial_data_out <= out_sr_reg[22];
                end else if (s2_reg.chain_enable_pin) begin
                    serial_data_out <= shift_reg[23];
                end
            end
        end
    end

    // Busy, load pulse handling, wake state and analog float.
    assign busy_now = (seq_reg != dac_host_serial_pkg::SEQ_IDLE) || (count_reg != '0)
                   || (exec_cnt_reg != 8'h00);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            busy_n           <= 1'b0;
            outputs_hiz      <= 1'b1;
            load_pending_reg <= 1'b0;
            dac_update_pulse <= 1'b0;
            interface_awake  <= 1'b0;
        end else begin
            busy_n           <= !busy_now;
            outputs_hiz      <= (seq_reg == dac_host_serial_pkg::SEQ_POR);
            dac_update_pulse <= 1'b0;
            if (seq_block) begin
                load_pending_reg <= 1'b0;
            end else if (busy_now) begin
                load_pending_reg <= load_pending_reg || load_fall || !s2_reg.load_n;
            end else if (load_pending_reg || load_fall) begin
                load_pending_reg <= 1'b0;
                dac_update_pulse <= 1'b1;
            end
            if ((par_mode && wr_fall) || (ser_en && sync_fall)) begin
                interface_awake <= 1'b1;
            end else if (s2_reg.wr_n && s2_reg.sync_n && !busy_now) begin
                interface_awake <= 1'b0;
            end
        end
    end

    // APB slave with one wait state.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ready_reg      <= 1'b0;
            prdata         <= 32'h00000000;
            pslverr        <= 1'b0;
            toggle_reg     <= 1'b0;
            power_down     <= 1'b0;
            clear_code_reg <= dac_host_serial_pkg::CLEAR_CODE_RESET;
        end else if (psel && penable && !ready_reg) begin
            ready_reg <= 1'b1;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
            case (paddr)
                dac_host_serial_pkg::CTRL_OFFSET: begin
                    prdata[dac_host_serial_pkg::CTRL_TOGGLE_BIT] <= toggle_reg;
                    prdata[dac_host_serial_pkg::CTRL_PWRDN_BIT]  <= power_down;
                end
                dac_host_serial_pkg::CLEAR_CODE_OFFSET: prdata[11:0] <= clear_code_reg;
                dac_host_serial_pkg::STATUS_OFFSET: begin
                    prdata[dac_host_serial_pkg::STAT_BUSY_BIT]   <= !busy_n;
                    prdata[dac_host_serial_pkg::STAT_FIFO_BIT]   <= fifo_active_reg;
                    prdata[dac_host_serial_pkg::STAT_AWAKE_BIT]  <= interface_awake;
                    prdata[dac_host_serial_pkg::STAT_SERIAL_BIT] <= !par_mode;
                    prdata[dac_host_serial_pkg::STAT_LEVEL_LSB +: QW+1] <= count_reg;
                end
                dac_host_serial_pkg::LAST_FRAME_OFFSET: prdata[23:0] <= last_frame_reg;
                dac_host_serial_pkg::BAD_FRAMES_OFFSET: prdata[15:0] <= bad_frames_reg;
                default: pslverr <= 1'b1;
            endcase
        end else begin
            ready_reg <= 1'b0;
            pslverr   <= 1'b0;
            if (psel && penable && pwrite) begin
                case (paddr)
                    dac_host_serial_pkg::CTRL_OFFSET: begin
                        toggle_reg <= pwdata[dac_host_serial_pkg::CTRL_TOGGLE_BIT];
                        power_down <= pwdata[dac_host_serial_pkg::CTRL_PWRDN_BIT];
                    end
                    dac_host_serial_pkg::CLEAR_CODE_OFFSET: clear_code_reg <= pwdata[11:0];
                    default: ;
                endcase
            end
        end
    end
    assign pready = ready_reg;

    // Frame statistics.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_frame_reg <= 24'h000000;
            bad_frames_reg <= 16'h0000;
        end else if (frame_good) begin
            last_frame_reg <= shift_reg;
        end else if (frame_end) begin
            bad_frames_reg <= bad_frames_reg + 16'h0001;
        end
    end

    property p_busy_in_seq;
        @(posedge clk_sys) disable iff (srst)
        (seq_reg != dac_host_serial_pkg::SEQ_IDLE) |=> !busy_n;
    endproperty
    a_busy_in_seq: assert property (p_busy_in_seq) else $error("busy high in sequence");

    property p_full_ignored;
        @(posedge clk_sys) disable iff (srst)
        (par_write && count_reg == cap) |=> count_reg <= $past(count_reg);
    endproperty
    a_full_ignored: assert property (p_full_ignored) else $error("full queue grew");

    property p_serial_cap;
        @(posedge clk_sys) disable iff (srst)
        !par_mode |-> count_reg <= (QW+1)'(1);
    endproperty
    a_serial_cap: assert property (p_serial_cap) else $error("queue deep in serial mode");

    property p_bad_frame;
        @(posedge clk_sys) disable iff (srst)
        (frame_end && bit_cnt_reg != dac_host_serial_pkg::FRAME_BITS)
            |-> !push ##1 (bad_frames_reg == $past(bad_frames_reg) + 16'h0001);
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("short frame not dropped");

    property p_count_limit;
        @(posedge clk_sys) disable iff (srst)
        bit_cnt_reg <= dac_host_serial_pkg::FRAME_BITS;
    endproperty
    a_count_limit: assert property (p_count_limit) else $error("bit count past frame");

    property p_reset_busy;
        @(posedge clk_sys) disable iff (srst)
        (seq_reg == dac_host_serial_pkg::SEQ_IDLE && reset_fall) |=> ##1 !busy_n[*8];
    endproperty
    a_reset_busy: assert property (p_reset_busy) else $error("reset did not hold busy");

    property p_load_ignored;
        @(posedge clk_sys) disable iff (srst)
        seq_block |=> !dac_update_pulse;
    endproperty
    a_load_ignored: assert property (p_load_ignored) else $error("load during reset");

    property p_sdo_edge;
        @(posedge clk_sys) disable iff (srst)
        $changed(serial_data_out) |-> $past(sclk_rise) || $past(sync_fall);
    endproperty
    a_sdo_edge: assert property (p_sdo_edge) else $error("output moved off edge");

    property p_wake;
        @(posedge clk_sys) disable iff (srst)
        (ser_en && sync_fall) |=> interface_awake;
    endproperty
    a_wake: assert property (p_wake) else $error("interface not awake");

    c_good_frame: cover property (@(posedge clk_sys) disable iff (srst) frame_good);
    c_readback: cover property (@(posedge clk_sys) disable iff (srst) rb_active_reg && sclk_rise);
    c_queue_full: cover property (@(posedge clk_sys) disable iff (srst) par_write && count_reg == cap);
endmodule
`default_nettype wire

// >>> rtl/dac_host_serial_pkg.sv
// Shared constants and types for the DAC host interface front end.
package dac_host_serial_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int POR_TIME_NS   = 270000;
    localparam int RESET_TIME_NS = 270000;
    localparam int CLEAR_TIME_NS = 35000;
    localparam logic [11:0] POR_CYCLES   = 12'(POR_TIME_NS / CLK_PERIOD_NS);
    localparam logic [11:0] RESET_CYCLES = 12'(RESET_TIME_NS / CLK_PERIOD_NS);
    localparam logic [11:0] CLEAR_CYCLES = 12'(CLEAR_TIME_NS / CLK_PERIOD_NS);
    localparam logic [4:0]  FRAME_BITS   = 5'h18;
    localparam logic [9:0]  STORE_SIZE   = 10'h200;
    // Register select codes inside a frame or a parallel write.
    localparam logic [1:0] REG_SEL_SPECIAL = 2'h0;
    localparam logic [1:0] REG_SEL_GAIN    = 2'h1;
    localparam logic [1:0] REG_SEL_OFFSET  = 2'h2;
    localparam logic [1:0] REG_SEL_DATA    = 2'h3;
    // Values after reset.
    localparam logic [11:0] GAIN_RESET  = 12'hFFF;
    localparam logic [11:0] OTHER_RESET = 12'h000;
    localparam logic [11:0] CLEAR_CODE_RESET = 12'h000;
    // Register offsets on the APB bus.
    localparam logic [7:0] CTRL_OFFSET       = 8'h00;
    localparam logic [7:0] CLEAR_CODE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET     = 8'h08;
    localparam logic [7:0] LAST_FRAME_OFFSET = 8'h0C;
    localparam logic [7:0] BAD_FRAMES_OFFSET = 8'h10;
    // Field positions.
    localparam int CTRL_TOGGLE_BIT = 0;
    localparam int CTRL_PWRDN_BIT  = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_FIFO_BIT   = 1;
    localparam int STAT_AWAKE_BIT  = 2;
    localparam int STAT_SERIAL_BIT = 3;
    localparam int STAT_LEVEL_LSB  = 8;

    typedef struct packed {
        logic        bank;
        logic        read;
        logic [5:0]  channel_address;
        logic [1:0]  reg_sel;
        logic [11:0] data_word;
        logic [1:0]  pad;
    } frame_type;

    typedef struct packed {
        logic        bank;
        logic [5:0]  channel_address;
        logic [1:0]  reg_sel;
        logic [11:0] data_word;
    } instr_type;

    typedef struct packed {
        logic        reset_n;
        logic        clear_n;
        logic        load_n;
        logic        serial_parallel_select;
        logic        bus_select;
        logic        chain_enable_pin;
        logic        fifo_enable;
        logic        cs_n;
        logic        wr_n;
        logic        sync_n;
        logic        sclk;
        logic        din;
        logic [5:0]  channel_address;
        logic [1:0]  reg_sel;
        logic [11:0] data_word;
    } pin_type;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_POR, SEQ_RESET, SEQ_CLEAR} seq_type;
endpackage

// >>> verification/host_serial_master.sv
// Host serial master model that frames words onto the serial port.
`timescale 1ns/10ps
`default_nettype none
module host_serial_master (
    // Clock.
    input  wire logic clk_sys,
    // Serial lines.
    input  wire logic serial_data_out,
    output var  logic sync_n,
    output var  logic sclk,
    output var  logic din
);
    logic [23:0] rx = 24'h000000;
    initial begin
        sync_n = 1'b1;
        sclk = 1'b1;
        din = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk_sys);
    endtask
    // Sends n clocks of word, most significant bit first, and keeps what came back.
    task automatic frame(input logic [23:0] w, input int n);
        sync_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            din <= w[23 - (i % 24)];
            half();
            sclk <= 1'b0;
            rx <= {rx[22:0], serial_data_out};
            half();
            sclk <= 1'b1;
        end
        half();
        sync_n <= 1'b1;
        din <= ~din;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_dac_host_serial_interface.sv
// Self-checking bench for the serial port, readback and reset sequencing.
`timescale 1ns/10ps
`default_nettype none
module tb_dac_host_serial_interface;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, q;
    logic pready, pslverr, busy_n, serial_data_out, outputs_hiz, reg_write_valid, e;
    logic sync_n, sclk, din;
    logic [23:0] fr, rq;
    dac_host_serial_pkg::pin_type pv, pins;
    dac_host_serial_pkg::instr_type reg_write_instr, got[$];
    int n_mismatch = 0;
    int compares = 0;
    always #50 clk_sys = ~clk_sys;
    always_comb begin
        pins = pv;
        pins.sync_n = sync_n;
        pins.sclk = sclk;
        pins.din = din;
    end
    dac_host_serial_interface dut (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pins, .busy_n, .serial_data_out,
        .dac_update_pulse(), .outputs_hiz, .interface_awake(), .power_down(),
        .reg_write_valid, .reg_write_instr);
    host_serial_master host (.clk_sys, .serial_data_out, .sync_n, .sclk, .din);
    always @(posedge clk_sys) if (reg_write_valid === 1'b1) got.push_back(reg_write_instr);
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] a);
        compares++;
        if (a !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, x, a);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            t++;
        end while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1) n_mismatch++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic summarize();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        summarize();
    end
    initial begin
        pv = '1;
        pv.bus_select = 1'b0;
        pv.chain_enable_pin = 1'b0;
        void'($urandom(84502));
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("busy_n", 32'h0, busy_n);
        chk("outputs_hiz", 32'h1, outputs_hiz);
        for (int t = 0; t < 3000 && busy_n !== 1'b1; t++) @(posedge clk_sys);
        chk("busy_n", 32'h1, busy_n);
        apb(1'b1, 8'h40, 32'h00000000);
        chk("pslverr", 32'h1, e);
        @(posedge clk_sys);
        apb(1'b0, dac_host_serial_pkg::STATUS_OFFSET, 32'h0);
        chk("fifo_active", 32'h1, q[dac_host_serial_pkg::STAT_FIFO_BIT]);
        for (int k = 0; k < 3; k++) begin
            fr = {2'h0, 6'($urandom_range(39)), 2'h3, 12'($urandom), 2'h0};
            host.frame(fr, (k == 1) ? 20 : 24 + 6 * k);
            repeat (30) @(posedge clk_sys);
            chk("writes", (k == 1) ? 0 : 1, got.size());
            if (k != 1) chk("instr", {11'h0, 1'b0, fr[21:2]}, got.pop_front());
            if (k != 1) rq = {2'h1, fr[21:14], 12'($urandom), 2'h0};
        end
        apb(1'b0, dac_host_serial_pkg::BAD_FRAMES_OFFSET, 32'h0);
        chk("bad_frames", 32'h1, q);
        host.frame(rq, 24);
        repeat (30) @(posedge clk_sys);
        chk("writes", 32'h0, got.size());
        host.frame(24'h000000, 24);
        repeat (30) @(posedge clk_sys);
        chk("readback", {rq[23:14], fr[13:2], 2'h0}, host.rx);
        chk("writes", 32'h1, got.size());
        got.delete();
        pv.chain_enable_pin <= 1'b1;
        fr = {2'h0, 6'($urandom_range(39)), 2'h2, 12'($urandom), 2'h0};
        host.frame(fr, 48);
        repeat (30) @(posedge clk_sys);
        chk("chain_out", fr, host.rx);
        chk("writes", 32'h1, got.size());
        chk("instr", {12'h0, fr[21:2]}, got.pop_front());
        pv.reset_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk("busy_n", 32'h0, busy_n);
        host.frame(fr, 24);
        pv.reset_n <= 1'b1;
        for (int t = 0; t < 3000 && busy_n !== 1'b1; t++) @(posedge clk_sys);
        chk("busy_n", 32'h1, busy_n);
        chk("writes", 32'h0, got.size());
        rq = {2'h1, fr[21:16], 2'h1, 12'h000, 2'h0};
        host.frame(rq, 24);
        repeat (30) @(posedge clk_sys);
        host.frame(24'h000000, 24);
        repeat (30) @(posedge clk_sys);
        chk("gain", {rq[23:14], dac_host_serial_pkg::GAIN_RESET, 2'h0}, host.rx);
        summarize();
    end
endmodule
`default_nettype wire
